// [ctc_pkg.sv]
// Constants and types for the interrupt status and counter/timer block
package ctc_pkg;

  // Register addresses (read meaning / write meaning)
  localparam logic [3:0] ADDR_CHANGE_AUX = 4'h4;
  localparam logic [3:0] ADDR_STATUS_MASK = 4'h5;
  localparam logic [3:0] ADDR_UPPER = 4'h6;
  localparam logic [3:0] ADDR_LOWER = 4'h7;
  localparam logic [3:0] ADDR_START = 4'hE;
  localparam logic [3:0] ADDR_STOP = 4'hF;

  // Reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [15:0] PRESET_RESET = 16'h0002;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Auxiliary control fields
  localparam int AUX_MODE_MSB = 6;
  localparam int AUX_MODE_LSB = 4;
  localparam int AUX_TIMER_BIT = 6;

  // Clock source codes of the mode field
  localparam logic [2:0] SRC_CNT_AUX = 3'h0;
  localparam logic [2:0] SRC_CNT_AUX_DIV = 3'h1;
  localparam logic [2:0] SRC_CNT_TXCLK = 3'h2;
  localparam logic [2:0] SRC_CNT_SYS_DIV = 3'h3;
  localparam logic [2:0] SRC_TMR_AUX = 3'h4;
  localparam logic [2:0] SRC_TMR_AUX_DIV = 3'h5;
  localparam logic [2:0] SRC_TMR_SYS = 3'h6;
  localparam logic [2:0] SRC_TMR_SYS_DIV = 3'h7;

  // Prescaler wraps after sixteen counts
  localparam logic [3:0] DIV16_LAST = 4'hF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [1:0] FIFO_LEVEL_TWO = 2'h2;
  localparam logic [1:0] FIFO_LEVEL_ONE = 2'h1;

  typedef enum logic [0:0] {
    CT_IDLE = 1'b0,
    CT_RUN = 1'b1
  } ct_state_type;

endpackage : ctc_pkg

// [ctc_status_timer.sv]
// Interrupt status, mask and 16-bit counter/timer of one serial block
module ctc_status_timer (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] aux_input,
  input wire logic tx_clock_1x,
  input wire logic [1:0] break_change,
  input wire logic [1:0] reset_break_cmd,
  input wire logic [1:0] rx_fifo_write,
  input wire logic [1:0] rx_fifo_read,
  input wire logic [3:0] rx_fifo_level,
  input wire logic [1:0] rx_shift_waiting,
  input wire logic [1:0] rx_full_select,
  input wire logic [1:0] transmit_ready_flag,
  output logic interrupt_out_n,
  output logic multipurpose_output
);
  import ctc_pkg::*;

  logic [7:0] mask_r;
  logic [7:0] aux_ctrl_r;
  logic [7:0] preset_hi_r;
  logic [7:0] preset_lo_r;
  logic [3:0] aux_prev_r;
  logic [3:0] change_r;
  logic in_change_r;
  logic [1:0] break_r;
  logic [1:0] rx_r;
  logic tx_prev_r;
  logic [3:0] aux_div_r;
  logic [3:0] sys_div_r;
  logic [15:0] count_r;
  logic wave_r;
  logic ready_r;
  ct_state_type state_r;
  logic [7:0] rdata_r;
  logic irq_n_r;

  logic [15:0] count_nxt;
  logic wave_nxt;
  logic ready_nxt;
  ct_state_type state_nxt;
  logic [1:0] rx_nxt;
  logic tick;

  // Register decode
  wire rd_change = reg_rd && (reg_addr == ADDR_CHANGE_AUX);
  wire wr_aux = reg_wr && (reg_addr == ADDR_CHANGE_AUX);
  wire wr_mask = reg_wr && (reg_addr == ADDR_STATUS_MASK);
  wire wr_upper = reg_wr && (reg_addr == ADDR_UPPER);
  wire wr_lower = reg_wr && (reg_addr == ADDR_LOWER);
  wire start_cmd = reg_rd && (reg_addr == ADDR_START);
  wire stop_cmd = reg_rd && (reg_addr == ADDR_STOP);
  wire rd_status = reg_rd && (reg_addr == ADDR_STATUS_MASK);
  wire rd_upper = reg_rd && (reg_addr == ADDR_UPPER);
  wire rd_lower = reg_rd && (reg_addr == ADDR_LOWER);

  wire [15:0] preset = {preset_hi_r, preset_lo_r};
  wire timer_mode = aux_ctrl_r[AUX_TIMER_BIT];
  wire [2:0] src_sel = aux_ctrl_r[AUX_MODE_MSB:AUX_MODE_LSB];

  // Input change detection
  wire [3:0] change_now = aux_input ^ aux_prev_r;
  wire in_change_set = |(change_now & aux_ctrl_r[3:0]);

  // Clock source edges and prescalers
  wire aux_rise = aux_input[1] & ~aux_prev_r[1];
  wire tx_rise = tx_clock_1x & ~tx_prev_r;
  wire aux_div_tick = aux_rise && (aux_div_r == DIV16_LAST);
  wire sys_div_tick = (sys_div_r == DIV16_LAST);

  // Status image; transmit bits are live copies
  // Transmit-ready copies
  wire [7:0] status = {in_change_r, break_r[1], rx_r[1], transmit_ready_flag[1],
                       ready_r, break_r[0], rx_r[0], transmit_ready_flag[0]};

  always_comb
  begin
    unique case (src_sel)
      SRC_CNT_AUX, SRC_TMR_AUX: tick = aux_rise;
      SRC_CNT_AUX_DIV, SRC_TMR_AUX_DIV: tick = aux_div_tick;
      SRC_CNT_TXCLK: tick = tx_rise;
      SRC_CNT_SYS_DIV, SRC_TMR_SYS_DIV: tick = sys_div_tick;
      SRC_TMR_SYS: tick = 1'b1;
    endcase
  end

  // Receiver status per channel
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_rx
    wire [1:0] level = rx_fifo_level[2*ch +: 2];
    wire full_set = rx_fifo_write[ch] && (level == FIFO_LEVEL_TWO);
    wire full_clr = rx_fifo_read[ch] && !rx_shift_waiting[ch];
    // Ready variant, re-set when more remain
    wire rdy_set = rx_fifo_write[ch] || (rx_fifo_read[ch] && (level > FIFO_LEVEL_ONE));
    wire rdy_clr = rx_fifo_read[ch];
    wire set_now = rx_full_select[ch] ? full_set : rdy_set;
    wire clr_now = rx_full_select[ch] ? full_clr : rdy_clr;
    assign rx_nxt[ch] = set_now | (rx_r[ch] & ~clr_now);
  end

  // Counter/timer step qualifiers
  wire running = (state_r == CT_RUN);
  wire counter_halt = stop_cmd && !timer_mode;
  wire step = running && tick && !counter_halt;
  wire at_one = (count_r == COUNT_ONE);

  // Counter/timer next state
  always_comb
  begin
    count_nxt = count_r;
    wave_nxt = wave_r;
    ready_nxt = ready_r;
    state_nxt = state_r;
    // Stop clears ready; timer keeps going
    if (stop_cmd)
    begin
      ready_nxt = 1'b0;
      if (!timer_mode)
      begin
        state_nxt = CT_IDLE;
        wave_nxt = 1'b1;
      end
    end
    if (start_cmd)
    begin
      // Preset taken only here in counter mode
      count_nxt = preset;
      wave_nxt = 1'b1;
      state_nxt = CT_RUN;
    end
    // One step per source edge while running
    else if (step)
    begin
      if (timer_mode && at_one)
      begin
        count_nxt = preset;
        wave_nxt = ~wave_r;
        if (!wave_r)
          ready_nxt = 1'b1;
      end
      else if (at_one)
      begin
        count_nxt = COUNT_RESET;
        ready_nxt = 1'b1;
        wave_nxt = 1'b0;
      end
      else
        count_nxt = count_r - COUNT_ONE;
    end
  end

  // Read data mux
  wire [7:0] change_image = {change_r, aux_input};
  wire [7:0] rdata_nxt =
    rd_change ? change_image :
    rd_status ? status :
    rd_upper ? count_r[15:8] :
    rd_lower ? count_r[7:0] : 8'h00;

  // Host control registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mask_r <= MASK_RESET;
      aux_ctrl_r <= AUX_RESET;
    end
    else
    begin
      if (wr_mask)
        mask_r <= reg_wdata;
      if (wr_aux)
        aux_ctrl_r <= reg_wdata;
    end
  end

  // Preset bytes
  // Preset is write-only
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      preset_hi_r <= PRESET_RESET[15:8];
      preset_lo_r <= PRESET_RESET[7:0];
    end
    else
    begin
      if (wr_upper)
        preset_hi_r <= reg_wdata;
      if (wr_lower)
        preset_lo_r <= reg_wdata;
    end
  end

  // Input change flags; a set in the clearing cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      aux_prev_r <= 4'h0;
      change_r <= 4'h0;
      in_change_r <= 1'b0;
    end
    else
    begin
      aux_prev_r <= aux_input;
      change_r <= change_now | (change_r & {4{~rd_change}});
      // Set by change, cleared by change register read
      in_change_r <= in_change_set | (in_change_r & ~rd_change);
    end
  end

  // Break change flags; set wins
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      break_r <= 2'h0;
    end
    else
    begin
      break_r <= break_change | (break_r & ~reset_break_cmd);
    end
  end

  // Receiver status and transmit clock history
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rx_r <= 2'h0;
      tx_prev_r <= 1'b0;
    end
    else
    begin
      rx_r <= rx_nxt;
      tx_prev_r <= tx_clock_1x;
    end
  end

  // Divide-by-sixteen prescalers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      aux_div_r <= 4'h0;
      sys_div_r <= 4'h0;
    end
    else
    begin
      if (aux_rise)
        aux_div_r <= aux_div_r + 4'h1;
      sys_div_r <= sys_div_r + 4'h1;
    end
  end

  // Counter/timer state
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      count_r <= COUNT_RESET;
      wave_r <= 1'b1;
      ready_r <= 1'b0;
      state_r <= CT_IDLE;
    end
    else
    begin
      count_r <= count_nxt;
      wave_r <= wave_nxt;
      ready_r <= ready_nxt;
      state_r <= state_nxt;
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // Registered interrupt output
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      irq_n_r <= 1'b1;
    end
    else
    begin
      // Mask gates the output, never the read
      irq_n_r <= ~|(status & mask_r);
    end
  end

  assign reg_rdata = rdata_r;
  assign interrupt_out_n = irq_n_r;
  assign multipurpose_output = wave_r;

endmodule : ctc_status_timer

// [ctc_status_timer_properties.sv]
// Port checker for the status and counter/timer block
module ctc_status_timer_properties
  import ctc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] transmit_ready_flag,
  input wire logic interrupt_out_n,
  input wire logic multipurpose_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic timer_r;
  logic run_r;
  logic [7:0] mask_r;
  wire logic start_rd = reg_rd && reg_addr == ADDR_START;
  wire logic stop_rd = reg_rd && reg_addr == ADDR_STOP;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      timer_r <= 1'b0;
      run_r <= 1'b0;
      mask_r <= MASK_RESET;
    end
    else
    begin
      if (reg_wr && reg_addr == ADDR_CHANGE_AUX)
        timer_r <= reg_wdata[AUX_TIMER_BIT];
      if (reg_wr && reg_addr == ADDR_STATUS_MASK)
        mask_r <= reg_wdata;
      if (start_rd)
        run_r <= 1'b1;
      else if (stop_rd && !timer_r)
        run_r <= 1'b0;
    end
  end
  sequence stop_cnt;
    stop_rd && !timer_r;
  endsequence
  cmd_read_a: assert property (start_rd || stop_rd |=> reg_rdata == 8'h00)
    else $error("command read returned data");
  stop_high_a: assert property (stop_cnt |=> multipurpose_output)
    else $error("output low after stop");
  stop_clear_a: assert property (stop_cnt ##0 mask_r == 8'h08 |=> ##1 interrupt_out_n)
    else $error("counter ready kept after stop");
  idle_high_a: assert property (!run_r |-> multipurpose_output)
    else $error("output low while idle");
  ready_int_a: assert property ($fell(multipurpose_output) && !timer_r && mask_r[3] |=> !interrupt_out_n)
    else $error("no interrupt at terminal count");
  mask_off_a: assert property ($past(mask_r) == 8'h00 |-> interrupt_out_n)
    else $error("interrupt with all masked");
  tx_copy_a: assert property ($past(mask_r) == 8'h01 |-> interrupt_out_n == !$past(transmit_ready_flag[0]))
    else $error("transmit copy wrong");
  half_min_a: assert property (timer_r && $changed(multipurpose_output) |=> $stable(multipurpose_output))
    else $error("half period below two");
endmodule : ctc_status_timer_properties

bind ctc_status_timer ctc_status_timer_properties chk_inst (.sys_clk, .reset_n, .reg_addr, .reg_rd, .reg_wr,
  .reg_wdata, .reg_rdata, .transmit_ready_flag, .interrupt_out_n, .multipurpose_output);

// [ctc_host_model.sv]
// Host CPU model on the register bus
module ctc_host_model (
  input wire logic sys_clk,
  output logic [3:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_addr = 4'h0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : ctc_host_model

// [ctc_status_timer_tb.sv]
// Self-checking bench for the status and counter/timer block
module ctc_status_timer_tb;
  import ctc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tx_clock_1x = 1'b0;
  logic [3:0] aux_input = 4'h0, rx_fifo_level = 4'h0, reg_addr;
  logic [1:0] brk = 2'b00, brk_clr = 2'b00, fifo_wr = 2'b00, fifo_rd = 2'b00, txr = 2'b00;
  logic [1:0] full_sel = 2'b00, shift_wait = 2'b00;
  logic reg_rd, reg_wr, interrupt_out_n, multipurpose_output;
  logic [7:0] reg_wdata, reg_rdata, v;
  int err_total = 0;
  int total_checks = 0;
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  ctc_host_model host (.sys_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata);
  ctc_status_timer ctc_status_timer_inst (.sys_clk, .reset_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata, .aux_input, .tx_clock_1x, .break_change(brk), .reset_break_cmd(brk_clr),
    .rx_fifo_write(fifo_wr), .rx_fifo_read(fifo_rd), .rx_fifo_level, .rx_shift_waiting(shift_wait),
    .rx_full_select(full_sel), .transmit_ready_flag(txr), .interrupt_out_n, .multipurpose_output);
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task st(input logic [7:0] e);
    host.rd(ADDR_STATUS_MASK, v);
    chk("status", v, e);
  endtask : st
  task txp(input int n);
    repeat (n)
    begin
      @(posedge sys_clk) tx_clock_1x <= 1'b1;
      @(posedge sys_clk) tx_clock_1x <= 1'b0;
    end
  endtask : txp
  task wait_out(input logic e);
    for (int i = 0; i < 40 && multipurpose_output !== e; i++)
      @(posedge sys_clk) #1;
    if (multipurpose_output !== e)
    begin
      err_total++;
      end_of_test();
    end
  endtask : wait_out
  task half(input logic [7:0] e);
    logic c;
    int n;
    c = multipurpose_output;
    n = 0;
    while (multipurpose_output === c && n < 40)
    begin
      @(posedge sys_clk) #1;
      n++;
    end
    chk("half", n[7:0], e);
  endtask : half
  task reset_scn;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk("out", multipurpose_output, 8'h01);
  endtask : reset_scn
  task tx_copy_scn;
    @(posedge sys_clk) txr <= 2'b10;
    host.wr(ADDR_STATUS_MASK, 8'h01);
    st(8'h10);
    chk("irq", interrupt_out_n, 8'h01);
    @(posedge sys_clk) txr <= 2'b01;
    st(8'h01);
    chk("irq", interrupt_out_n, 8'h00);
    @(posedge sys_clk) txr <= 2'b00;
  endtask : tx_copy_scn
  task break_scn;
    @(posedge sys_clk) brk <= 2'b11;
    @(posedge sys_clk) brk <= 2'b00;
    st(8'h44);
    @(posedge sys_clk) brk_clr <= 2'b01;
    @(posedge sys_clk) brk_clr <= 2'b00;
    st(8'h40);
  endtask : break_scn
  task change_scn;
    host.wr(ADDR_CHANGE_AUX, 8'h01);
    @(posedge sys_clk) aux_input <= 4'h4;
    repeat (2) @(posedge sys_clk);
    st(8'h40);
    @(posedge sys_clk) aux_input <= 4'h5;
    repeat (2) @(posedge sys_clk);
    st(8'hC0);
    host.rd(ADDR_CHANGE_AUX, v);
    chk("change", v, 8'h55);
    @(posedge sys_clk) brk_clr <= 2'b10;
    @(posedge sys_clk) brk_clr <= 2'b00;
    st(8'h00);
  endtask : change_scn
  task rx_ready_scn;
    @(posedge sys_clk) fifo_wr <= 2'b01;
    @(posedge sys_clk) fifo_wr <= 2'b00;
    st(8'h02);
    @(posedge sys_clk) fifo_rd <= 2'b01;
    rx_fifo_level <= 4'h2;
    @(posedge sys_clk) fifo_rd <= 2'b00;
    st(8'h02);
    @(posedge sys_clk) fifo_rd <= 2'b01;
    rx_fifo_level <= 4'h1;
    @(posedge sys_clk) fifo_rd <= 2'b00;
    st(8'h00);
  endtask : rx_ready_scn
  task rx_full_scn;
    @(posedge sys_clk) full_sel <= 2'b01;
    rx_fifo_level <= 4'h2;
    fifo_wr <= 2'b01;
    @(posedge sys_clk) fifo_wr <= 2'b00;
    st(8'h02);
    @(posedge sys_clk) fifo_rd <= 2'b01;
    rx_fifo_level <= 4'h3;
    shift_wait <= 2'b01;
    @(posedge sys_clk) fifo_rd <= 2'b00;
    st(8'h02);
    @(posedge sys_clk) fifo_wr <= 2'b01;
    rx_fifo_level <= 4'h2;
    @(posedge sys_clk) fifo_wr <= 2'b00;
    shift_wait <= 2'b00;
    st(8'h02);
    @(posedge sys_clk) fifo_rd <= 2'b01;
    rx_fifo_level <= 4'h3;
    @(posedge sys_clk) fifo_rd <= 2'b00;
    st(8'h00);
    @(posedge sys_clk) full_sel <= 2'b00;
    rx_fifo_level <= 4'h0;
  endtask : rx_full_scn
  task counter_scn;
    host.wr(ADDR_CHANGE_AUX, 8'h20);
    host.wr(ADDR_UPPER, 8'h00);
    host.wr(ADDR_LOWER, 8'h03);
    host.wr(ADDR_STATUS_MASK, 8'h08);
    host.rd(ADDR_START, v);
    chk("cmd", v, 8'h00);
    host.wr(ADDR_LOWER, 8'h09);
    txp(2);
    chk("out", multipurpose_output, 8'h01);
    txp(1);
    st(8'h08);
    chk("irq", interrupt_out_n, 8'h00);
    chk("out", multipurpose_output, 8'h00);
    host.rd(ADDR_LOWER, v);
    chk("low", v, 8'h00);
    txp(1);
    host.rd(ADDR_UPPER, v);
    chk("high", v, 8'hFF);
    host.rd(ADDR_STOP, v);
    st(8'h00);
    chk("out", multipurpose_output, 8'h01);
    host.rd(ADDR_START, v);
    txp(3);
    st(8'h00);
    host.rd(ADDR_STOP, v);
  endtask : counter_scn
  task timer_scn;
    host.wr(ADDR_CHANGE_AUX, 8'h60);
    host.wr(ADDR_LOWER, 8'h05);
    host.rd(ADDR_START, v);
    half(8'h05);
    half(8'h05);
    st(8'h08);
    host.rd(ADDR_STOP, v);
    st(8'h00);
    wait_out(1'b0);
    wait_out(1'b1);
    host.wr(ADDR_LOWER, 8'h02);
    half(8'h03);
    half(8'h02);
    host.rd(ADDR_START, v);
    chk("out", multipurpose_output, 8'h01);
    half(8'h02);
  endtask : timer_scn
  initial
  begin
    reset_scn();
    tx_copy_scn();
    break_scn();
    change_scn();
    rx_ready_scn();
    rx_full_scn();
    counter_scn();
    timer_scn();
    end_of_test();
  end
endmodule : ctc_status_timer_tb
